// ### shared/dpcap_defines.vh
`ifndef DPCAP_DEFINES_VH
`define DPCAP_DEFINES_VH
// Parameter addresses, 16-bit word address space
`define DPCAP_ADDR_STATUS 12'ha02
`define DPCAP_ADDR_EDGE1 12'ha04
`define DPCAP_ADDR_EDGE2 12'ha06
`define DPCAP_ADDR_ARM1 12'ha08
`define DPCAP_ADDR_ARM2 12'ha0a
`define DPCAP_ADDR_POS1 12'ha0c
`define DPCAP_ADDR_POS2 12'ha0e
`define DPCAP_ADDR_CNT1 12'ha10
`define DPCAP_ADDR_CNT2 12'ha12
// Arming values
`define DPCAP_ARM_STOP 2'h0
`define DPCAP_ARM_ONCE 2'h1
`define DPCAP_ARM_CONT 2'h2
// Status bit positions
`define DPCAP_ST_UNIT1 0
`define DPCAP_ST_UNIT2 1
// Reset values
`define DPCAP_RST_POS 32'h0000_0000
`define DPCAP_RST_CNT 16'h0000
`define DPCAP_RST_EDGE 1'b0
`endif

// ### hw/dpcap_unit.v
`timescale 1ns/1ps
`include "dpcap_defines.vh"
module dpcap_unit #(
	parameter POS_W = 32,
	parameter CNT_W = 16
) (
	input wire mclk,
	input wire rst_n,
	input wire cap_pin,
	input wire edge_rise,
	input wire arm_wr,
	input wire [1:0] arm_val,
	input wire [POS_W-1:0] position,
	input wire ref_shift,
	input wire [POS_W-1:0] ref_delta,
	output reg [1:0] mode,
	output reg [POS_W-1:0] latched,
	output reg [CNT_W-1:0] count,
	output reg done
);
	reg [2:0] sync;
	reg level;
	wire agree;
	wire capture;
	// A change counts only once stages two and three agree
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			sync <= 3'h0;
			level <= 1'b0;
		end else begin
			sync <= {sync[1:0], cap_pin};
			if (agree) begin
				level <= sync[2];
			end
		end
	end
	assign agree = (sync[1] == sync[2]);
	assign capture = (mode != `DPCAP_ARM_STOP) && agree && (sync[2] != level) &&
		(edge_rise ? sync[2] : ~sync[2]);
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode <= `DPCAP_ARM_STOP;
			latched <= `DPCAP_RST_POS;
			count <= `DPCAP_RST_CNT;
			done <= 1'b0;
		end else begin
			if (arm_wr) begin
				// Unknown arming values set the mode to stop, but unlike a stop they still clear count and done
				mode <= (arm_val == `DPCAP_ARM_ONCE || arm_val == `DPCAP_ARM_CONT) ?
					arm_val : `DPCAP_ARM_STOP;
				if (arm_val != `DPCAP_ARM_STOP) begin
					count <= `DPCAP_RST_CNT;
					done <= 1'b0;
				end
			end else if (capture) begin
				latched <= position;
				count <= count + 1'b1;
				done <= 1'b1;
				if (mode == `DPCAP_ARM_ONCE) begin
					mode <= `DPCAP_ARM_STOP;
				end
			end
			if (ref_shift && !(capture && !arm_wr)) begin
				latched <= latched + ref_delta;
			end
		end
	end
endmodule

// ### hw/dpcap_top.v
`timescale 1ns/1ps
`include "dpcap_defines.vh"
// Summary of operation
// - Arming value 0 cancels, 1 starts single capture, 2 starts continuous.
// - Single capture stops by itself after the first latched position.
// - Continuous capture latches on every qualifying edge until cancelled.
// - Edge select 0 captures on falling edge, 1 on rising edge.
// - Each unit counts capture events in an unsigned 16-bit counter.
// - Event counter clears whenever the unit is armed.
// - Capture stores the signed 32-bit user position into the latched register.
// - Position set or homing shifts stored positions to the new reference.
// - Status bit 0 set when the first input captured.
// - Status bit 1 set when the second input captured.
module dpcap_top #(
	parameter POS_W = 32,
	parameter CNT_W = 16
) (
	input wire mclk,
	input wire arst_n,
	input wire first_capture_input,
	input wire second_capture_input,
	input wire [POS_W-1:0] user_position,
	input wire ref_shift,
	input wire [POS_W-1:0] ref_delta,
	input wire par_wr,
	input wire par_rd,
	input wire [11:0] par_addr,
	input wire [POS_W-1:0] par_wdata,
	output reg [POS_W-1:0] par_rdata,
	output reg par_rvalid,
	output reg par_err
);
	reg [1:0] rst_sync;
	reg edge1;
	reg edge2;
	wire rst_n;
	wire arm1_wr;
	wire arm2_wr;
	wire [1:0] mode1;
	wire [1:0] mode2;
	wire [POS_W-1:0] pos1;
	wire [POS_W-1:0] pos2;
	wire [CNT_W-1:0] cnt1;
	wire [CNT_W-1:0] cnt2;
	wire done1;
	wire done2;
	reg [POS_W-1:0] next_rdata;
	reg next_err;

	always @(posedge mclk or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync <= 2'h0;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	assign arm1_wr = par_wr && (par_addr == `DPCAP_ADDR_ARM1);
	assign arm2_wr = par_wr && (par_addr == `DPCAP_ADDR_ARM2);

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			edge1 <= `DPCAP_RST_EDGE;
			edge2 <= `DPCAP_RST_EDGE;
		end else if (par_wr) begin
			if (par_addr == `DPCAP_ADDR_EDGE1) begin
				edge1 <= par_wdata[0];
			end
			if (par_addr == `DPCAP_ADDR_EDGE2) begin
				edge2 <= par_wdata[0];
			end
		end
	end

	dpcap_unit #(.POS_W(POS_W), .CNT_W(CNT_W)) u_one (
		.mclk(mclk),
		.rst_n(rst_n),
		.cap_pin(first_capture_input),
		.edge_rise(edge1),
		.arm_wr(arm1_wr),
		.arm_val(par_wdata[1:0]),
		.position(user_position),
		.ref_shift(ref_shift),
		.ref_delta(ref_delta),
		.mode(mode1),
		.latched(pos1),
		.count(cnt1),
		.done(done1)
	);

	dpcap_unit #(.POS_W(POS_W), .CNT_W(CNT_W)) u_two (
		.mclk(mclk),
		.rst_n(rst_n),
		.cap_pin(second_capture_input),
		.edge_rise(edge2),
		.arm_wr(arm2_wr),
		.arm_val(par_wdata[1:0]),
		.position(user_position),
		.ref_shift(ref_shift),
		.ref_delta(ref_delta),
		.mode(mode2),
		.latched(pos2),
		.count(cnt2),
		.done(done2)
	);

	// Read mux; 16-bit values sit in the low bits
	always @* begin
		next_rdata = {POS_W{1'b0}};
		next_err = 1'b0;
		case (par_addr)
		`DPCAP_ADDR_STATUS: begin
			next_rdata[`DPCAP_ST_UNIT1] = done1;
			next_rdata[`DPCAP_ST_UNIT2] = done2;
		end
		`DPCAP_ADDR_EDGE1: next_rdata[0] = edge1;
		`DPCAP_ADDR_EDGE2: next_rdata[0] = edge2;
		`DPCAP_ADDR_ARM1: next_rdata[1:0] = mode1;
		`DPCAP_ADDR_ARM2: next_rdata[1:0] = mode2;
		`DPCAP_ADDR_POS1: next_rdata = pos1;
		`DPCAP_ADDR_POS2: next_rdata = pos2;
		`DPCAP_ADDR_CNT1: next_rdata[CNT_W-1:0] = cnt1;
		`DPCAP_ADDR_CNT2: next_rdata[CNT_W-1:0] = cnt2;
		default: next_err = 1'b1;
		endcase
	end

	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			par_rdata <= {POS_W{1'b0}};
			par_rvalid <= 1'b0;
			par_err <= 1'b0;
		end else begin
			par_rvalid <= par_rd;
			par_err <= (par_rd | par_wr) & next_err;
			if (par_rd) begin
				par_rdata <= next_rdata;
			end
		end
	end
endmodule

// ### test/dpcap_monitor.sv
`timescale 1ns/1ps
module dpcap_monitor #(
	parameter POS_W = 32
) (
	input wire mclk,
	input wire arst_n,
	input wire par_wr,
	input wire par_rd,
	input wire [11:0] par_addr,
	input wire [POS_W-1:0] par_rdata,
	input wire par_rvalid,
	input wire par_err
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!arst_n);
	wire [11:0] a = par_addr;
	wire ok = a >= 12'ha02 && a <= 12'ha12 && !a[0];
	a_rd_answer: assert property (par_rvalid == $past(par_rd)) else $error("rvalid");
	a_err_unmapped: assert property (par_err == $past((par_rd | par_wr) & !ok)) else $error("err");
	a_rdata_hold: assert property (!par_rvalid |-> $stable(par_rdata)) else $error("hold");
	a_status_bits: assert property (par_rd && a == 12'ha02 |=> par_rdata < 4)
		else $error("status");
	a_edge_bit: assert property (par_rd && a inside {12'ha04, 12'ha06} |=> par_rdata < 2)
		else $error("edge");
	a_arm_code: assert property (par_rd && a inside {12'ha08, 12'ha0a} |=> par_rdata < 3)
		else $error("arm");
	a_count_width: assert property (par_rd && a inside {12'ha10, 12'ha12} |=> par_rdata < 32'h10000)
		else $error("count");
	a_wr_quiet: assert property (par_wr && !par_rd && !ok |=> par_err && !par_rvalid)
		else $error("wr");
endmodule
bind dpcap_top dpcap_monitor #(.POS_W(POS_W)) u_mon (.mclk(mclk), .arst_n(arst_n),
	.par_wr(par_wr), .par_rd(par_rd), .par_addr(par_addr), .par_rdata(par_rdata),
	.par_rvalid(par_rvalid), .par_err(par_err));

// ### test/dpcap_partner.sv
`timescale 1ns/1ps
module dpcap_partner (
	output reg [1:0] pins
);
	initial pins = 2'h0;
	// Off-grid edge, like a field sensor
	task flip(input int u);
		pins[u] <= #3 ~pins[u];
	endtask
endmodule

// ### test/dual_position_capture_test.sv
`timescale 1ns/1ps
module dual_position_capture_test;
	logic mclk = 0, arst_n = 0, ref_shift = 0, par_wr = 0, par_rd = 0;
	logic [11:0] par_addr = '0;
	logic [31:0] user_position = '0, ref_delta = '0, par_wdata = '0, par_rdata, e[9];
	logic par_rvalid, par_err;
	wire [1:0] pins;
	int error_cnt = 0, total_checks = 0, seed = 32'hb6411cf4, u;
	int cnt[2], mode[2], edg[2], lvl[2], pos[2], st;
	initial forever #5 mclk = ~mclk;
	dpcap_partner p (.pins(pins));
	dpcap_top dut (.mclk(mclk), .arst_n(arst_n), .first_capture_input(pins[0]),
		.second_capture_input(pins[1]), .user_position(user_position),
		.ref_shift(ref_shift), .ref_delta(ref_delta), .par_wr(par_wr), .par_rd(par_rd),
		.par_addr(par_addr), .par_wdata(par_wdata), .par_rdata(par_rdata),
		.par_rvalid(par_rvalid), .par_err(par_err));
	task chk(input [31:0] g, input [31:0] x);
		total_checks++;
		if (g !== x) begin
			error_cnt++;
			$display("ERROR t=%0t got %h exp %h", $time, g, x);
		end
	endtask
	task xfer(input bit w, input [11:0] a, input [31:0] d);
		@(posedge mclk);
		par_wr <= w;
		par_rd <= !w;
		par_addr <= a;
		par_wdata <= d;
		@(posedge mclk);
		par_wr <= 0;
		par_rd <= 0;
		#1;
	endtask
	task rdall;
		e = '{st, edg[0], edg[1], mode[0], mode[1], pos[0], pos[1], cnt[0], cnt[1]};
		for (int i = 0; i < 9; i++) begin
			xfer(0, 12'(12'ha02 + 2 * i), 32'h0);
			chk(par_rdata, e[i]);
		end
	endtask
	task cap(input int v);
		@(posedge mclk);
		user_position <= $random(seed);
		@(posedge mclk);
		p.flip(v);
		lvl[v] = !lvl[v];
		if (mode[v] != 0 && lvl[v] == edg[v]) begin
			pos[v] = user_position;
			cnt[v]++;
			st[v] = 1;
			mode[v] = mode[v] == 2 ? 2 : 0;
		end
		repeat (6) @(posedge mclk);
	endtask
	task report_and_stop;
		$display("checks %0d errors %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		#20us;
		error_cnt++;
		report_and_stop;
	end
	initial begin
		repeat (6) @(posedge mclk);
		arst_n <= 1;
		repeat (3) @(posedge mclk);
		rdall;
		xfer(0, 12'ha14, 32'h0);
		chk({31'h0, par_err}, 32'h1);
		xfer(1, 12'ha14, 32'h0);
		chk({31'h0, par_err}, 32'h1);
		$display("reset test done");
		for (int k = 0; k < 8; k++) begin
			u = k / 4;
			edg[u] = k % 2;
			mode[u] = k / 2 % 2 + 1;
			cnt[u] = 0;
			st[u] = 0;
			xfer(1, 12'(12'ha04 + 2 * u), 32'(edg[u]));
			xfer(1, 12'(12'ha08 + 2 * u), 32'(mode[u]));
			repeat (3) cap(u);
			rdall;
			$display("capture test %0d done", k);
		end
		@(posedge mclk);
		ref_shift <= 1;
		ref_delta <= $random(seed);
		@(posedge mclk);
		ref_shift <= 0;
		pos[0] += ref_delta;
		pos[1] += ref_delta;
		rdall;
		mode = '{0, 0};
		xfer(1, 12'ha08, 32'h0);
		xfer(1, 12'ha0a, 32'h0);
		cap(0);
		cap(1);
		rdall;
		$display("shift and cancel test done");
		report_and_stop;
	end
endmodule
